// ===== common/avcmb_pkg.sv
package avcmb_pkg;

	// ************************************************************
	// Register map (byte addresses of aligned words).
	// ************************************************************
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_MASK   = 8'h04;
	localparam logic [7:0] REG_CUR    = 8'h08;
	localparam logic [7:0] REG_SLICE  = 8'h0C;
	localparam logic [7:0] REG_WIDTH  = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_START  = 8'h18;

	localparam int CTRL_RAW   = 0;
	localparam int CTRL_INTRA = 1;
	localparam int CTRL_PAIR  = 2;
	localparam int CTRL_BWD   = 3;
	localparam int CTRL_FWD   = 4;
	localparam int CTRL_PART  = 5;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [8:0]  MASK_RESET = 9'h000;

	localparam int STAT_BUSY = 0;
	localparam int STAT_ERR  = 1;
	localparam int STAT_NB   = 8;
	localparam int STAT_BLK  = 16;
	localparam int START_GO  = 0;

	// ************************************************************
	// Coefficient word layout.
	// ************************************************************
	localparam int VAL_HI  = 31;
	localparam int VAL_LO  = 16;
	localparam int RSV_HI  = 15;
	localparam int RSV_LO  = 7;
	localparam int POS_HI  = 6;
	localparam int POS_LO  = 1;
	localparam int LAST_B  = 0;
	localparam logic [5:0] LUMA_DC_MAX   = 6'h0F;
	localparam logic [5:0] CHROMA_DC_MAX = 6'h03;

	// ************************************************************
	// Block order inside one macroblock.
	// ************************************************************
	localparam int         NBLK     = 9;
	localparam logic [3:0] BLK_LDC  = 4'h0;
	localparam logic [3:0] BLK_CBDC = 4'h5;
	localparam logic [3:0] BLK_CRDC = 4'h6;
	localparam logic [3:0] BLK_NONE = 4'h9;

	localparam logic [6:0] PIX_LAST_WORD = 7'h5F;
	localparam logic [2:0] PIX_LAST_SUB  = 3'h3;
	localparam int         PIX_BITS      = 8;
	localparam int         REF_BITS      = 4;
	localparam logic [3:0] REF_NONE      = 4'hF;

	localparam logic [1:0] PART_16X16 = 2'h0;
	localparam logic [1:0] PART_16X8  = 2'h1;
	localparam logic [1:0] PART_8X16  = 2'h2;

	localparam logic [1:0] KIND_COEF = 2'h0;
	localparam logic [1:0] KIND_PIX  = 2'h1;
	localparam logic [1:0] KIND_REF  = 2'h2;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_COEF = 4'b0010,
		ST_PIX  = 4'b0100,
		ST_REF  = 4'b1000
	} avcmb_state_t;

endpackage

// ===== core/avcmb_unpacker.sv
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module avcmb_unpacker
	import avcmb_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic [31:0] in_word,
	input  wire logic        in_valid,
	output logic             in_ready,
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic [1:0]       out_kind,
	output logic [15:0]      out_value,
	output logic [5:0]       out_pos,
	output logic [3:0]       out_block,
	output logic             out_last,
	output logic             out_ref_absent,
	output logic [4:0]       intra_neighbour_flags,
	output logic             busy
);

	// ************************************************************
	// Helper functions.
	// ************************************************************
	function automatic logic [3:0] next_block(input logic [4:0] from, input logic [8:0] m);
		logic [3:0] r;
		r = BLK_NONE;
		for (int i = NBLK - 1; i >= 0; i--) begin
			if (5'(i) >= from && m[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	function automatic logic nb_ok(input logic signed [17:0] a, input logic [15:0] cur,
		input logic [15:0] first);
		return (a >= $signed({2'b00, first})) && (a <= $signed({2'b00, cur}));
	endfunction

	function automatic logic [2:0] ref_last(input logic [1:0] part);
		if (part == PART_16X16) begin
			return 3'h0;
		end else if (part == PART_16X8 || part == PART_8X16) begin
			return 3'h1;
		end
		return 3'h3;
	endfunction

	// ************************************************************
	// Register bus slave.
	// ************************************************************
	logic [31:0]  ctrl_r;
	logic [8:0]   mask_r;
	logic [15:0]  cur_r;
	logic [15:0]  slice_r;
	logic [15:0]  width_r;
	logic         err_r;
	logic         dp_we_r;
	logic [7:0]   dp_addr_r;
	logic [31:0]  hrdata_r;
	logic [4:0]   nb_r;
	logic [3:0]   blk_r;
	avcmb_state_t state_r;
	logic         acc;
	logic         start;
	logic         err_set;
	logic [31:0]  rd_mux;

	assign acc = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign start = dp_we_r && dp_addr_r == REG_START && hwdata[START_GO] && state_r == ST_IDLE;

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (haddr[7:0])
			REG_CTRL:   rd_mux = ctrl_r;
			REG_MASK:   rd_mux = {23'h000000, mask_r};
			REG_CUR:    rd_mux = {16'h0000, cur_r};
			REG_SLICE:  rd_mux = {16'h0000, slice_r};
			REG_WIDTH:  rd_mux = {16'h0000, width_r};
			REG_STATUS: begin
				rd_mux[STAT_BUSY] = busy;
				rd_mux[STAT_ERR] = err_r;
				rd_mux[STAT_NB +: 5] = nb_r;
				rd_mux[STAT_BLK +: 4] = blk_r;
			end
			default:    rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dp_we_r <= 1'b0;
			dp_addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
		end else begin
			dp_we_r <= acc && hwrite;
			if (acc) begin
				dp_addr_r <= haddr[7:0];
			end
			if (acc && !hwrite) begin
				hrdata_r <= rd_mux;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= CTRL_RESET;
			mask_r <= MASK_RESET;
			cur_r <= 16'h0000;
			slice_r <= 16'h0000;
			width_r <= 16'h0000;
		end else if (dp_we_r) begin
			unique case (dp_addr_r)
				REG_CTRL:  ctrl_r <= hwdata;
				REG_MASK:  mask_r <= hwdata[8:0];
				REG_CUR:   cur_r <= hwdata[15:0];
				REG_SLICE: slice_r <= hwdata[15:0];
				REG_WIDTH: width_r <= hwdata[15:0];
				default:   ctrl_r <= ctrl_r;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			err_r <= 1'b0;
		end else if (err_set) begin
			err_r <= 1'b1;
		end else if (dp_we_r && dp_addr_r == REG_STATUS && hwdata[STAT_ERR]) begin
			err_r <= 1'b0;
		end
	end

	// ************************************************************
	// Neighbour availability.
	// ************************************************************
	logic               pair;
	logic [15:0]        unit;
	logic signed [17:0] ua;
	logic signed [17:0] ub;
	logic signed [17:0] uc;
	logic signed [17:0] ud;
	logic signed [17:0] aa;
	logic signed [17:0] ab;
	logic signed [17:0] ac;
	logic signed [17:0] ad;
	logic               left_edge;
	logic               right_edge;
	logic [4:0]         nb_nxt;

	assign pair = ctrl_r[CTRL_PAIR];
	assign unit = pair ? {1'b0, cur_r[15:1]} : cur_r;
	assign ua = $signed({2'b00, unit}) - 18'sd1;
	assign ub = $signed({2'b00, unit}) - $signed({2'b00, width_r});
	assign uc = ub + 18'sd1;
	assign ud = ub - 18'sd1;
	assign aa = pair ? (ua <<< 1) : ua;
	assign ab = pair ? (ub <<< 1) : ub;
	assign ac = pair ? (uc <<< 1) : uc;
	assign ad = pair ? (ud <<< 1) : ud;
	assign left_edge = (width_r == 16'h0000) || (unit % width_r) == 16'h0000;
	assign right_edge = (width_r == 16'h0000) ||
		(17'({1'b0, unit} + 17'h00001) % {1'b0, width_r}) == 17'h00000;

	always_comb begin
		nb_nxt[0] = nb_ok(ad, cur_r, slice_r) && !left_edge;
		nb_nxt[1] = nb_ok(ac, cur_r, slice_r) && !right_edge;
		nb_nxt[2] = nb_ok(ab, cur_r, slice_r);
		nb_nxt[3] = nb_ok(aa, cur_r, slice_r) && !left_edge;
		nb_nxt[4] = pair && nb_nxt[3];
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			nb_r <= 5'h00;
		end else begin
			nb_r <= nb_nxt;
		end
	end

	assign intra_neighbour_flags = nb_r;

	// ************************************************************
	// Unpacking sequencer.
	// ************************************************************
	logic [8:0]  eff_mask;
	logic [3:0]  first_blk;
	logic [3:0]  adv_blk;
	logic        slot_free;
	logic        take;
	logic        emit;
	logic [1:0]  e_kind;
	logic [15:0] e_value;
	logic [5:0]  e_pos;
	logic [3:0]  e_block;
	logic        e_last;
	logic        e_absent;
	logic [31:0] buf_r;
	logic        buf_full_r;
	logic [2:0]  sub_r;
	logic [6:0]  wcnt_r;
	logic        list_r;
	logic [8:0]  samp;
	logic [2:0]  sub_end;
	logic        out_valid_r;
	logic        ref_fwd;
	logic        ref_bwd;

	assign eff_mask = {mask_r[8:1], mask_r[0] & ctrl_r[CTRL_INTRA]};
	assign first_blk = next_block(5'h00, eff_mask);
	assign adv_blk = next_block(5'({1'b0, blk_r} + 5'h01), eff_mask);
	assign ref_fwd = ctrl_r[CTRL_FWD];
	assign ref_bwd = ctrl_r[CTRL_BWD];
	assign slot_free = !out_valid_r || out_ready;
	assign in_ready = (state_r == ST_COEF) ? slot_free :
		((state_r == ST_PIX || state_r == ST_REF) && !buf_full_r);
	assign take = in_valid && in_ready;
	assign samp = {wcnt_r, sub_r[1:0]};
	assign sub_end = (state_r == ST_PIX) ? PIX_LAST_SUB : ref_last(ctrl_r[CTRL_PART +: 2]);
	assign busy = state_r != ST_IDLE;

	always_comb begin
		emit = 1'b0;
		e_kind = KIND_COEF;
		e_value = 16'h0000;
		e_pos = 6'h00;
		e_block = blk_r;
		e_last = 1'b0;
		e_absent = 1'b0;
		err_set = 1'b0;
		unique case (state_r)
			ST_IDLE: emit = 1'b0;
			ST_COEF: begin
				emit = take;
				e_value = in_word[VAL_HI:VAL_LO];
				e_pos = in_word[POS_HI:POS_LO];
				e_last = in_word[LAST_B];
				err_set = take && (in_word[RSV_HI:RSV_LO] != 9'h000 ||
					(blk_r == BLK_LDC && e_pos > LUMA_DC_MAX) ||
					((blk_r == BLK_CBDC || blk_r == BLK_CRDC) && e_pos > CHROMA_DC_MAX));
			end
			ST_PIX: begin
				emit = buf_full_r && slot_free;
				e_kind = KIND_PIX;
				e_value = {8'h00, buf_r[sub_r[1:0] * PIX_BITS +: PIX_BITS]};
				e_pos = samp[5:0];
				e_block = {1'b0, samp[8:6]};
				e_last = sub_r == PIX_LAST_SUB && wcnt_r == PIX_LAST_WORD;
			end
			ST_REF: begin
				emit = buf_full_r && slot_free;
				e_kind = KIND_REF;
				e_value = {12'h000, buf_r[sub_r * REF_BITS +: REF_BITS]};
				e_pos = {3'h0, sub_r};
				e_block = {3'h0, list_r};
				e_last = sub_r == sub_end;
				e_absent = e_value[3:0] == REF_NONE;
			end
			default: emit = 1'b0;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			blk_r <= BLK_NONE;
			list_r <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (start && ctrl_r[CTRL_RAW]) begin
						state_r <= ST_PIX;
					end else if (start && first_blk != BLK_NONE) begin
						state_r <= ST_COEF;
						blk_r <= first_blk;
					end else if (start && (ref_fwd || ref_bwd)) begin
						state_r <= ST_REF;
						list_r <= !ref_fwd;
					end
				end
				ST_COEF: begin
					if (take && in_word[LAST_B]) begin
						blk_r <= adv_blk;
						if (adv_blk == BLK_NONE) begin
							state_r <= (ref_fwd || ref_bwd) ? ST_REF : ST_IDLE;
							list_r <= !ref_fwd;
						end
					end
				end
				ST_PIX: begin
					if (emit && e_last) begin
						state_r <= ST_IDLE;
					end
				end
				ST_REF: begin
					if (emit && e_last) begin
						if (!list_r && ref_bwd) begin
							list_r <= 1'b1;
						end else begin
							state_r <= ST_IDLE;
						end
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			buf_r <= 32'h0000_0000;
			buf_full_r <= 1'b0;
			sub_r <= 3'h0;
			wcnt_r <= 7'h00;
		end else begin
			if (start) begin
				wcnt_r <= 7'h00;
				sub_r <= 3'h0;
			end
			if (take && state_r != ST_COEF) begin
				buf_r <= in_word;
				buf_full_r <= 1'b1;
				sub_r <= 3'h0;
			end else if (emit && state_r != ST_COEF) begin
				if (sub_r == sub_end) begin
					buf_full_r <= 1'b0;
					wcnt_r <= 7'(wcnt_r + 7'h01);
				end else begin
					sub_r <= 3'(sub_r + 3'h1);
				end
			end
		end
	end

	// ************************************************************
	// Output holding register.
	// ************************************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			out_valid_r <= 1'b0;
			out_kind <= KIND_COEF;
			out_value <= 16'h0000;
			out_pos <= 6'h00;
			out_block <= 4'h0;
			out_last <= 1'b0;
			out_ref_absent <= 1'b0;
		end else begin
			if (emit) begin
				out_valid_r <= 1'b1;
				out_kind <= e_kind;
				out_value <= e_value;
				out_pos <= e_pos;
				out_block <= e_block;
				out_last <= e_last;
				out_ref_absent <= e_absent;
			end else if (out_ready) begin
				out_valid_r <= 1'b0;
			end
		end
	end

	assign out_valid = out_valid_r;

endmodule

// ===== verification/avcmb_buffer_model.sv
`timescale 1ns/1ps
module avcmb_buffer_model
	import avcmb_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	output logic [31:0]      in_word,
	output logic             in_valid,
	input  wire logic        in_ready
);
	logic [31:0] q[$];
	initial begin
		in_word = 32'h0000_0000;
		in_valid = 1'b0;
	end
	task automatic push(input logic [31:0] w);
		q.push_back(w);
	endtask
	// Words leave in load order, with random gaps; idle data keeps toggling.
	always @(posedge clock) begin
		if (!in_valid || in_ready) begin
			if (nrst && q.size() > 0 && $urandom_range(3) != 0) begin
				in_word <= q.pop_front();
				in_valid <= 1'b1;
			end else begin
				in_word <= ~in_word;
				in_valid <= 1'b0;
			end
		end
	end
endmodule

// ===== verification/avcmb_unpacker_monitor.sv
`timescale 1ns/1ps
module avcmb_monitor
	import avcmb_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [31:0] in_word,
	input  wire logic        in_valid,
	input  wire logic        in_ready,
	input  wire logic        out_valid,
	input  wire logic        out_ready,
	input  wire logic [1:0]  out_kind,
	input  wire logic [15:0] out_value,
	input  wire logic [5:0]  out_pos,
	input  wire logic [3:0]  out_block,
	input  wire logic        out_last,
	input  wire logic        out_ref_absent,
	input  wire logic [4:0]  intra_neighbour_flags,
	input  wire logic        busy
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	sequence s_take;
		in_valid && in_ready && (!out_valid || out_ready);
	endsequence
	sequence s_new(k);
		s_take ##1 (out_valid && out_kind == k);
	endsequence
	// A pixel word is buffered first, so its first sample shows two cycles after the take.
	sequence s_pix_first;
		s_take ##2 (out_valid && out_kind == KIND_PIX);
	endsequence
	property p_coef;
		s_new(KIND_COEF) |-> out_value == $past(in_word[31:16]) &&
			out_pos == $past(in_word[6:1]) && out_last == $past(in_word[0]);
	endproperty
	a_coef: assert property (p_coef) else $error("coefficient fields wrong");
	property p_pix;
		s_pix_first |-> out_value == {8'h00, $past(in_word[7:0], 2)};
	endproperty
	a_pix: assert property (p_pix) else $error("first sample wrong");
	property p_pixlast;
		out_valid && out_kind == KIND_PIX && out_last |-> out_block == 4'h5 && out_pos == 6'h3F;
	endproperty
	a_pixlast: assert property (p_pixlast) else $error("last sample misplaced");
	property p_ref;
		out_valid && out_kind == KIND_REF |-> out_value[15:4] == 12'h000 &&
			out_ref_absent == (out_value[3:0] == REF_NONE) && out_block <= 4'h1;
	endproperty
	a_ref: assert property (p_ref) else $error("reference index wrong");
	property p_hold;
		out_valid && !out_ready |=> out_valid && $stable(out_value) && $stable(out_pos) &&
			$stable(out_kind) && $stable(out_block) && $stable(out_last);
	endproperty
	a_hold: assert property (p_hold) else $error("output lost while stalled");
	property p_blk;
		out_valid && out_kind == KIND_COEF |-> out_block < BLK_NONE;
	endproperty
	a_blk: assert property (p_blk) else $error("block index out of range");
	property p_lower;
		intra_neighbour_flags[4] |-> intra_neighbour_flags[3];
	endproperty
	a_lower: assert property (p_lower) else $error("lower left differs from left");
	property p_idle;
		!busy |-> !in_ready;
	endproperty
	a_idle: assert property (p_idle) else $error("word taken while idle");
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench
	import avcmb_pkg::*;
;
	logic        clock, nrst, hsel, hwrite, hready, hreadyout, hresp, in_valid, in_ready;
	logic        out_valid, out_ready, out_last, out_ref_absent, busy;
	logic [1:0]  htrans, out_kind;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, in_word, rd, w;
	logic [15:0] out_value;
	logic [5:0]  out_pos;
	logic [3:0]  out_block;
	logic [4:0]  intra_neighbour_flags;
	logic [31:0] exp_q[$];
	int          errors, n_compared, c, s, wd;
	avcmb_unpacker i_dut (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .in_word, .in_valid, .in_ready, .out_valid,
		.out_ready, .out_kind, .out_value, .out_pos, .out_block, .out_last, .out_ref_absent,
		.intra_neighbour_flags, .busy);
	avcmb_buffer_model i_src (.clock, .nrst, .in_word, .in_valid, .in_ready);
	assign hready = hreadyout;
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) out_ready <= ($urandom_range(3) != 0);
	always @(posedge clock) begin
		if (nrst && out_valid && out_ready) begin
			cmp(exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFF_FFFF, {2'b00, out_kind, out_value,
				out_pos, out_block, out_last, out_ref_absent});
		end
	end
	// ****************
	// Helpers.
	// ****************
	function automatic logic [31:0] pk(input logic [1:0] k, input logic [15:0] v,
		input logic [5:0] p, input logic [3:0] b, input logic l);
		return {2'b00, k, v, p, b, l, k == KIND_REF && v[3:0] == REF_NONE};
	endfunction
	function automatic logic nb_ok(input int a);
		return a >= s && a <= c;
	endfunction
	function automatic logic [31:0] nb_exp(input logic pr);
		int p, m;
		logic [31:0] f;
		p = pr ? c / 2 : c;
		m = pr ? 2 : 1;
		f = 32'h0000_0000;
		f[3] = nb_ok(m * (p - 1)) && p % wd != 0;
		f[2] = nb_ok(m * (p - wd));
		f[1] = nb_ok(m * (p - wd + 1)) && (p + 1) % wd != 0;
		f[0] = nb_ok(m * (p - wd - 1)) && p % wd != 0;
		f[4] = pr && f[3];
		return f;
	endfunction
	task automatic cmp(input logic [31:0] e, input logic [31:0] a);
		n_compared++;
		if (a !== e) begin
			errors++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatched %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		k = 0;
		do begin @(posedge clock); k++; end while (hready !== 1'b1 && k < 50);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do begin @(posedge clock); k++; end while (hready !== 1'b1 && k < 100);
		rd = hrdata;
		if (k >= 100) begin
			errors++;
			give_verdict();
		end
	endtask
	task automatic drain();
		int k;
		k = 0;
		do begin @(posedge clock); k++; end while ((busy !== 1'b0 || exp_q.size() > 0) && k < 5000);
		if (k >= 5000) begin
			errors++;
			give_verdict();
		end
		cmp({31'h0, busy}, 32'h0);
	endtask
	task automatic coef_mb(input logic [6:0] ctl, input logic [8:0] msk, input logic [8:0] rsv,
		input logic [5:0] pdc);
		logic [15:0] v;
		logic [5:0]  p;
		int          n, m;
		bus(1'b1, REG_CTRL, {25'h0, ctl});
		bus(1'b1, REG_MASK, {23'h0, msk});
		bus(1'b1, REG_START, 32'h0000_0001);
		for (int b = 0; b < NBLK; b++) begin
			if (msk[b] && (b != 0 || ctl[CTRL_INTRA])) begin
				n = 1 + $urandom_range(2);
				for (int i = 0; i < n; i++) begin
					v = 16'($signed(12'($urandom)));
					p = 6'($urandom) & (b == 0 ? LUMA_DC_MAX : (b == 5 || b == 6) ? CHROMA_DC_MAX : 6'h3F);
					p = (b == 0 || b == 5 || b == 6) ? p | pdc : p;
					i_src.push({v, i == 0 ? rsv : 9'h000, p, i == n - 1});
					exp_q.push_back(pk(KIND_COEF, v, p, 4'(b), i == n - 1));
				end
			end
		end
		m = ctl[6:5] == 2'h0 ? 1 : ctl[6:5] == 2'h3 ? 4 : 2;
		for (int l = 0; l < 2; l++) begin
			if (ctl[CTRL_FWD - l]) begin
				w = $urandom;
				w[3:0] = 4'hF;
				i_src.push(w);
				for (int i = 0; i < m; i++) begin
					exp_q.push_back(pk(KIND_REF, {12'h0, w[4*i +: 4]}, 6'(i), 4'(l), i == m - 1));
				end
			end
		end
		drain();
	endtask
	task automatic chk_err(input logic [31:0] e);
		bus(1'b0, REG_STATUS, 32'h0);
		cmp(rd & 32'h2, e);
		bus(1'b1, REG_STATUS, 32'h0000_0002);
	endtask
	// ****************
	// Main sequence.
	// ****************
	initial begin
		nrst = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		out_ready = 1'b0;
		errors = 0;
		n_compared = 0;
		void'($urandom(84));
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		exp_q.delete();
		for (int a = 0; a < 8; a++) begin
			bus(1'b1, 8'h1C, $urandom);
			bus(1'b0, a == 5 ? 8'h1C : 8'(4 * a), 32'h0);
			cmp(rd, 32'h0000_0000);
			cmp({30'h0, hreadyout, hresp}, 32'h0000_0002);
		end
		$display("test registers done");
		for (int t = 0; t < 40; t++) begin
			c = $urandom_range(40);
			s = $urandom_range(c);
			wd = 1 + $urandom_range(5);
			bus(1'b1, REG_CTRL, {29'h0, t[0], 2'h0});
			bus(1'b1, REG_CUR, 32'(c));
			bus(1'b1, REG_SLICE, 32'(s));
			bus(1'b1, REG_WIDTH, 32'(wd));
			bus(1'b0, REG_CUR, 32'h0);
			cmp(rd, 32'(c));
			bus(1'b0, REG_STATUS, 32'h0);
			cmp({27'h0, intra_neighbour_flags}, nb_exp(t[0]));
			cmp({27'h0, rd[12:8]}, nb_exp(t[0]));
		end
		$display("test neighbours done");
		coef_mb(7'h32, 9'h163, 9'h000, 6'h00);
		chk_err(32'h0);
		coef_mb(7'h78, 9'h01F, 9'h000, 6'h00);
		coef_mb(7'h48, 9'h000, 9'h000, 6'h00);
		coef_mb(7'h00, 9'h000, 9'h000, 6'h00);
		for (int t = 0; t < 4; t++) coef_mb(7'($urandom) & 7'h7E, 9'($urandom), 9'h000, 6'h00);
		coef_mb(7'h12, 9'h001, 9'h000, 6'h10);
		chk_err(32'h2);
		coef_mb(7'h00, 9'h002, 9'h001, 6'h00);
		chk_err(32'h2);
		$display("test coefficients done");
		bus(1'b1, REG_CTRL, 32'h0000_0011);
		bus(1'b1, REG_START, 32'h0000_0001);
		for (int i = 0; i < 96; i++) begin
			w = i == 0 ? 32'h0000_FF00 : $urandom;
			i_src.push(w);
			for (int j = 0; j < 4; j++) begin
				exp_q.push_back(pk(KIND_PIX, {8'h00, w[8*j +: 8]}, 6'(4*i + j), 4'((4*i + j) / 64),
					4*i + j == 383));
			end
		end
		drain();
		$display("test pixels done");
		give_verdict();
	end
endmodule
bind avcmb_unpacker avcmb_monitor i_mon (.clock, .nrst, .in_word, .in_valid, .in_ready,
	.out_valid, .out_ready, .out_kind, .out_value, .out_pos, .out_block, .out_last,
	.out_ref_absent, .intra_neighbour_flags, .busy);
